// ---- design/ccdrd_pkg.sv ----
// Package with timing constants, modes and states for the CCD readout sequencer
package ccdrd_pkg;
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_PS = 5000;
  // Horizontal clock period limits, in ps
  localparam int HCLK_MIN_PS = 25000;
  localparam int HCLK_NOM_PS = 50000;
  localparam int HCLK_MAX_PS = 200000;
  localparam int HCLK_HALF_CYC = (HCLK_NOM_PS / CLK_PERIOD_PS) / 2;
  // Vertical edge skew limit, in ps
  localparam int VEDGE_SKEW_MAX_PS = 100000;
  localparam int VEDGE_SKEW_CYC = VEDGE_SKEW_MAX_PS / CLK_PERIOD_PS;
  // Fast dump gate delay, in ps
  localparam int FDUMP_DELAY_PS = 500000;
  localparam int FDUMP_DELAY_CYC = (FDUMP_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Vertical step time per row shift phase
  localparam int VSTEP_CYC = 8;
  // Row and column counts
  localparam int ROWS_PROG = 2048;
  localparam int ROWS_FIELD = 1024;
  localparam int VSHIFT_SUMMED = 1037;
  localparam int COLS = 2048;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  typedef enum logic [1:0] {
    CCDRD_MODE_PROG = 2'b00,
    CCDRD_MODE_SUMMED = 2'b01,
    CCDRD_MODE_NONSUM = 2'b10
  } ccdrd_mode_e;
  typedef enum logic [2:0] {
    CCDRD_IDLE = 3'b000,
    CCDRD_DUMP = 3'b001,
    CCDRD_XFER = 3'b010,
    CCDRD_VSHIFT = 3'b011,
    CCDRD_HREAD = 3'b100,
    CCDRD_NEXTF = 3'b101
  } ccdrd_state_e;
endpackage

// ---- design/ccdrd_hclk_gen.sv ----
// Horizontal clock generator producing a fixed-period single-phase drive
module ccdrd_hclk_gen
  import ccdrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  output logic hclk,
  output logic pixel_done
);
  logic [CNT_W-1:0] div;
  logic [CNT_W-1:0] next_div;
  logic next_hclk;
  logic next_pixel_done;

  // Half period divider, nominal horizontal period
  always_comb begin
    next_div = div;
    next_hclk = hclk;
    next_pixel_done = 1'b0;
    if (!run) begin
      next_div = CNT_ZERO;
      next_hclk = 1'b0;
    end else if (div == CNT_W'(HCLK_HALF_CYC - 1)) begin
      next_div = CNT_ZERO;
      next_hclk = ~hclk;
      next_pixel_done = hclk;
    end else begin
      next_div = div + CNT_ONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div <= CNT_ZERO;
      hclk <= 1'b0;
      pixel_done <= 1'b0;
    end else begin
      div <= next_div;
      hclk <= next_hclk;
      pixel_done <= next_pixel_done;
    end
  end

  AST_HCLK_HIGH_HALF: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(hclk) |-> hclk [*5] ##1 !hclk)
    else $error("horizontal clock high phase wrong length");
endmodule

// ---- design/ccdrd_seq.sv ----
// Readout sequencer driving the CCD vertical, horizontal and dump pins
module ccdrd_seq
  import ccdrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic [1:0] mode,
  output logic v1,
  output logic v2,
  output logic v2_xfer,
  output logic xfer_odd,
  output logic fast_dump,
  output logic hclk,
  output logic line_valid,
  output logic field_odd,
  output logic busy,
  output logic frame_done
);
  ccdrd_state_e state;
  ccdrd_state_e next_state;
  ccdrd_mode_e cur_mode;
  ccdrd_mode_e next_cur_mode;
  logic [CNT_W-1:0] tmr;
  logic [CNT_W-1:0] next_tmr;
  logic [CNT_W-1:0] rows;
  logic [CNT_W-1:0] next_rows;
  logic [CNT_W-1:0] pix;
  logic [CNT_W-1:0] next_pix;
  logic next_v1, next_v2, next_v2_xfer, next_xfer_odd, next_fast_dump;
  logic next_line_valid, next_field_odd, next_busy, next_frame_done;
  logic h_run;
  logic h_clk_int;
  logic h_pix_done;

  // Row shifts per field for a mode
  function automatic logic [CNT_W-1:0] shifts_for(input ccdrd_mode_e m);
    case (m)
      CCDRD_MODE_PROG: shifts_for = CNT_W'(ROWS_PROG - 1);
      CCDRD_MODE_SUMMED: shifts_for = CNT_W'(VSHIFT_SUMMED - 1);
      default: shifts_for = CNT_W'(ROWS_FIELD - 1);
    endcase
  endfunction

  assign h_run = (state == CCDRD_HREAD);

  ccdrd_hclk_gen u_hclk (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(h_run),
    .hclk(h_clk_int),
    .pixel_done(h_pix_done)
  );

  always_comb begin
    next_state = state;
    next_cur_mode = cur_mode;
    next_tmr = tmr;
    next_rows = rows;
    next_pix = pix;
    next_v1 = v1;
    next_v2 = v2;
    next_v2_xfer = 1'b0;
    next_xfer_odd = xfer_odd;
    next_fast_dump = 1'b0;
    next_line_valid = 1'b0;
    next_field_odd = field_odd;
    next_busy = 1'b1;
    next_frame_done = 1'b0;
    case (state)
      CCDRD_IDLE: begin
        next_busy = 1'b0;
        if (start) begin
          next_cur_mode = (mode == 2'h1) ? CCDRD_MODE_SUMMED :
                          (mode == 2'h2) ? CCDRD_MODE_NONSUM : CCDRD_MODE_PROG;
          next_field_odd = 1'b0;
          next_busy = 1'b1;
          next_fast_dump = 1'b1;
          next_tmr = CNT_ZERO;
          next_state = CCDRD_DUMP;
        end
      end
      CCDRD_DUMP: begin
        // Hold off vertical edges after dump
        if (tmr == CNT_W'(FDUMP_DELAY_CYC - 1)) begin
          next_tmr = CNT_ZERO;
          next_v2_xfer = 1'b1;
          next_xfer_odd = (cur_mode == CCDRD_MODE_NONSUM) && field_odd;
          next_state = CCDRD_XFER;
        end else begin
          next_tmr = tmr + CNT_ONE;
        end
      end
      CCDRD_XFER: begin
        next_rows = shifts_for(cur_mode);
        next_tmr = CNT_ZERO;
        next_state = CCDRD_VSHIFT;
      end
      CCDRD_VSHIFT: begin
        // Both vertical phases toggle on the same edge
        next_tmr = tmr + CNT_ONE;
        if (tmr == CNT_W'(VSTEP_CYC - 1)) begin
          next_v1 = ~v1;
          next_v2 = ~v2;
          next_tmr = CNT_ZERO;
          if (v1) begin
            next_pix = CNT_ZERO;
            next_state = CCDRD_HREAD;
          end
        end
      end
      CCDRD_HREAD: begin
        next_line_valid = 1'b1;
        if (h_pix_done) begin
          next_pix = pix + CNT_ONE;
          if (pix == CNT_W'(COLS - 1)) begin
            next_line_valid = 1'b0;
            if (rows == CNT_ZERO) begin
              next_state = CCDRD_NEXTF;
            end else begin
              next_rows = rows - CNT_ONE;
              next_state = CCDRD_VSHIFT;
            end
          end
        end
      end
      CCDRD_NEXTF: begin
        // Interlaced: odd field follows even
        if (cur_mode != CCDRD_MODE_PROG && !field_odd) begin
          next_field_odd = 1'b1;
          next_fast_dump = 1'b1;
          next_tmr = CNT_ZERO;
          next_state = CCDRD_DUMP;
        end else begin
          next_frame_done = 1'b1;
          next_busy = 1'b0;
          next_state = CCDRD_IDLE;
        end
      end
      default: next_state = CCDRD_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= CCDRD_IDLE;
      cur_mode <= CCDRD_MODE_PROG;
      tmr <= CNT_ZERO;
      rows <= CNT_ZERO;
      pix <= CNT_ZERO;
      v1 <= 1'b0;
      v2 <= 1'b0;
      v2_xfer <= 1'b0;
      xfer_odd <= 1'b0;
      fast_dump <= 1'b0;
      hclk <= 1'b0;
      line_valid <= 1'b0;
      field_odd <= 1'b0;
      busy <= 1'b0;
      frame_done <= 1'b0;
    end else begin
      state <= next_state;
      cur_mode <= next_cur_mode;
      tmr <= next_tmr;
      rows <= next_rows;
      pix <= next_pix;
      v1 <= next_v1;
      v2 <= next_v2;
      v2_xfer <= next_v2_xfer;
      xfer_odd <= next_xfer_odd;
      fast_dump <= next_fast_dump;
      hclk <= h_clk_int;
      line_valid <= next_line_valid;
      field_odd <= next_field_odd;
      busy <= next_busy;
      frame_done <= next_frame_done;
    end
  end

  sequence s_dump;
    $rose(fast_dump);
  endsequence
  sequence s_quiet;
    !v2_xfer [*8];
  endsequence

  AST_DUMP_HOLDOFF: assert property (@(posedge clk_sys) disable iff (rst)
    s_dump |-> s_quiet)
    else $error("transfer too soon after fast dump");
  AST_DUMP_TO_XFER: assert property (@(posedge clk_sys) disable iff (rst)
    fast_dump |-> ##[100:110] v2_xfer)
    else $error("transfer not issued after dump delay");
  AST_PHASE_ALIGN: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(v1) |-> $changed(v2))
    else $error("vertical phases not aligned");
  AST_ODD_XFER_NONSUM: assert property (@(posedge clk_sys) disable iff (rst)
    v2_xfer && xfer_odd |-> field_odd && cur_mode == CCDRD_MODE_NONSUM)
    else $error("odd row transfer outside odd non-summed field");
  AST_SUMMED_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    state == CCDRD_XFER && cur_mode == CCDRD_MODE_SUMMED
      |=> rows == CNT_W'(VSHIFT_SUMMED - 1))
    else $error("summed field shift count wrong");
  AST_PROG_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    state == CCDRD_XFER && cur_mode == CCDRD_MODE_PROG
      |=> rows == CNT_W'(ROWS_PROG - 1))
    else $error("progressive row count wrong");
  AST_NONSUM_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    state == CCDRD_XFER && cur_mode == CCDRD_MODE_NONSUM
      |=> rows == CNT_W'(ROWS_FIELD - 1))
    else $error("non-summed row count wrong");
  AST_ODD_FOLLOWS: assert property (@(posedge clk_sys) disable iff (rst)
    state == CCDRD_NEXTF && cur_mode != CCDRD_MODE_PROG && !field_odd
      |=> field_odd && fast_dump)
    else $error("odd field not started after even field");
  AST_DONE_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    frame_done |-> !busy ##1 !frame_done)
    else $error("frame done pulse malformed");
endmodule

// ---- sim/ccdrd_sensor_model.sv ----
// Sensor model: loads rows on transfer, counts drive timing faults
module ccdrd_sensor_model
  import ccdrd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [1:0] mode,
  input wire logic v1,
  input wire logic v2,
  input wire logic v2_xfer,
  input wire logic xfer_odd,
  input wire logic field_odd,
  input wire logic fast_dump,
  input wire logic hclk,
  output int rows_held,
  output int first_row,
  output int viol
);
  timeunit 1ns;
  timeprecision 1ps;
  int hper = 0;
  int skew = 0;
  int since_dump = 1000;
  logic hq = 1'b0;
  logic vq = 1'b0;
  logic ilc;
  assign ilc = (mode == CCDRD_MODE_SUMMED) || (mode == CCDRD_MODE_NONSUM);
  always @(posedge clk_sys) begin
    hq <= hclk;
    vq <= v1;
    hper <= (hclk && !hq) ? 1 : hper + 1;
    skew <= (v1 != v2) ? skew + 1 : 0;
    since_dump <= fast_dump ? 0 : since_dump + 1;
    if (hclk && !hq && hper < 5) viol <= viol + 1;
    if (skew > 20) viol <= viol + 1;
    if (v2_xfer && since_dump < 99) viol <= viol + 1;
    if (v2_xfer) begin
      rows_held <= ilc ? ROWS_FIELD : ROWS_PROG;
      first_row <= (mode == CCDRD_MODE_SUMMED) ? int'(field_odd) :
        (mode == CCDRD_MODE_NONSUM) ? int'(xfer_odd) : 0;
    end else if (v1 && !vq && rows_held > 0) begin
      rows_held <= rows_held - 1;
    end
  end
endmodule

// ---- sim/ccdrd_seq_test.sv ----
// Testbench for the CCD readout sequencer with a sensor model
module ccdrd_seq_test
  import ccdrd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [1:0] mode = 2'b00;
  logic v1, v2, v2_xfer, xfer_odd, fast_dump, hclk, line_valid, field_odd, busy, frame_done;
  int rows_held, first_row, viol;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  always #2.5 clk_sys = ~clk_sys;
  ccdrd_seq i_ccdrd_seq (.clk_sys(clk_sys), .rst(rst), .start(start), .mode(mode), .v1(v1),
    .v2(v2), .v2_xfer(v2_xfer), .xfer_odd(xfer_odd), .fast_dump(fast_dump), .hclk(hclk),
    .line_valid(line_valid), .field_odd(field_odd), .busy(busy), .frame_done(frame_done));
  ccdrd_sensor_model i_ccdrd_sensor_model (.clk_sys(clk_sys), .mode(mode), .v1(v1), .v2(v2),
    .v2_xfer(v2_xfer), .xfer_odd(xfer_odd), .field_odd(field_odd), .fast_dump(fast_dump),
    .hclk(hclk), .rows_held(rows_held), .first_row(first_row), .viol(viol));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic do_reset();
    @(posedge clk_sys);
    rst <= 1'b1;
    start <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk("reset_out", 0, {v1, v2, v2_xfer, xfer_odd, fast_dump, hclk, line_valid, busy});
  endtask
  // Start held high, so a second start while busy must be ignored
  task automatic go(input logic [1:0] m, output int gap);
    int n;
    @(posedge clk_sys);
    start <= 1'b1;
    mode <= m;
    n = 0;
    do begin tick(); n++; end while (!fast_dump && n < 10);
    chk("start_to_dump", 1, n);
    chk("busy", 1, busy);
    gap = 0;
    do begin tick(); gap++; end while (!v2_xfer && gap < 200);
    chk("dump_to_xfer", 100, gap);
    tick();
  endtask
  task automatic t_prog();
    int gap, per, rises, badper, vtog, skewn, k, dumps;
    logic hq, vq, seen;
    go(2'b00, gap);
    chk("rows_loaded", ROWS_PROG, rows_held);
    chk("field_odd", 0, field_odd);
    {per, rises, badper, vtog, skewn, k, dumps} = '0;
    {hq, vq, seen} = {hclk, v1, 1'b0};
    while (!(seen && !line_valid) && k < 21000) begin
      tick();
      k++;
      per++;
      seen |= line_valid;
      if (fast_dump) dumps++;
      if (v1 !== vq) vtog++;
      if (v1 !== v2) skewn++;
      if (hclk && !hq) begin
        if (rises > 0 && per != HCLK_NOM_PS / CLK_PERIOD_PS) badper++;
        rises++;
        per = 0;
      end
      {hq, vq} = {hclk, v1};
    end
    chk("v_toggles", 2, vtog);
    chk("v_skew", 0, skewn);
    chk("hclk_count", COLS, rises);
    chk("hclk_period", 0, badper);
    chk("busy_hold", 1, busy);
    chk("restart_ignored", 0, dumps);
    chk("rows_left", ROWS_PROG - 1, rows_held);
    chk("frame_done", 0, frame_done);
    chk("drive_faults", 0, viol);
    do_reset();
  endtask
  task automatic t_field(input logic [1:0] m, input int exp_rows);
    int gap;
    go(m, gap);
    chk("rows_loaded", exp_rows, rows_held);
    chk("first_row", 0, first_row);
    chk("xfer_odd", 0, xfer_odd);
    chk("field_odd", 0, field_odd);
    chk("drive_faults", 0, viol);
    do_reset();
  endtask
  initial begin
    do_reset();
    t_prog();
    t_field(2'b01, ROWS_FIELD);
    t_field(2'b10, ROWS_FIELD);
    t_field(2'b11, ROWS_PROG);
    test_done();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      test_done();
    end
  end
endmodule
